// ### fsba_pkg.sv
// Shared constants and types for the parameter memory access control block.
// Assumes one clocked user of the package; no other dependencies.
package fsba_pkg;

	// Nonvolatile geometry
	localparam int          USER_BYTES    = 96;
	localparam int          BLOCK_BYTES   = 32;
	localparam int          USER_BLOCKS   = 3;
	localparam int          NUM_KEYS      = 4;

	// Host command space addresses
	localparam logic [7:0]  CMD_CONTROL   = 8'h00;
	localparam logic [7:0]  CMD_SUBCLASS  = 8'h3e;
	localparam logic [7:0]  CMD_BLOCK     = 8'h3f;
	localparam logic [7:0]  CMD_WIN_BASE  = 8'h40;
	localparam logic [7:0]  CMD_WIN_LAST  = 8'h5f;
	localparam logic [7:0]  CMD_CHECKSUM  = 8'h60;
	localparam logic [7:0]  CMD_SOURCE    = 8'h61;

	// Block source select values
	localparam logic [7:0]  SRC_GENERAL   = 8'h00;
	localparam logic [7:0]  SRC_AUTH      = 8'h01;

	// Subclasses and user block numbers
	localparam logic [7:0]  USER_SUBCLASS = 8'h3a;
	localparam logic [7:0]  KEY_SUBCLASS  = 8'h70;
	localparam logic [7:0]  USER_BLK_A    = 8'h01;
	localparam logic [7:0]  USER_BLK_C    = 8'h03;

	// Control subcommands
	localparam logic [15:0] SUB_SEAL      = 16'h0020;
	localparam logic [15:0] SUB_LOADER    = 16'h0f00;

	// Control status word bit positions
	localparam int          STAT_SS_BIT   = 13;
	localparam int          STAT_FAS_BIT  = 14;

	// APB byte offsets
	localparam logic [11:0] APB_STATUS    = 12'h000;
	localparam logic [11:0] APB_CTRL      = 12'h004;
	localparam logic [11:0] APB_KEY_BASE  = 12'h010;
	localparam logic [11:0] APB_KEY_LAST  = 12'h01c;
	localparam int          CTRL_EXIT_BIT = 0;

	// Key reset values, stored order (unseal 0, unseal 1, full 0, full 1)
	localparam logic [15:0] KEY_RST0      = 16'h1234;
	localparam logic [15:0] KEY_RST1      = 16'h5678;
	localparam logic [15:0] KEY_RST2      = 16'h9abc;
	localparam logic [15:0] KEY_RST3      = 16'hdef0;

	typedef enum logic [1:0] {
		FSBA_SEALED,
		FSBA_UNSEALED,
		FSBA_FULL,
		FSBA_LOADER
	} fsba_level_e;

	typedef struct packed {
		logic        write;
		logic [7:0]  addr;
		logic [15:0] data;
	} fsba_cmd_s;

	function automatic logic [15:0] fsba_swap16(input logic [15:0] w);
		fsba_swap16 = {w[7:0], w[15:8]};
	endfunction : fsba_swap16

endpackage : fsba_pkg

// ### fsba_top.sv
// Security levels, key sequences and user information block access.
// Host commands arrive on the link clock; APB and all state except the link side registers run on clk.
//
// Our own choices: the APB register port and the address map.
module fsba_top (
	// System
	input  wire logic        clk,
	input  wire logic        reset_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Host command link
	input  wire logic        linkClk,
	input  wire logic        linkReqValid,
	input  wire logic        linkReqWrite,
	input  wire logic [7:0]  linkReqAddr,
	input  wire logic [15:0] linkReqData,
	output logic             linkBusy,
	output logic             linkRspValid,
	output logic [15:0]      linkRspData,
	// Status
	output logic             sealedFlag,
	output logic             fullAccessStatusFlag,
	output logic [1:0]       securityLevel
);

	// Link side registers
	fsba_pkg::fsba_cmd_s linkCmd_r;
	logic                linkBusy_r;
	logic                linkReqTgl_r;
	logic                linkAckSync1_r;
	logic                linkAckSync2_r;
	logic                linkAckSync3_r;
	logic                linkRspValid_r;
	logic [15:0]         linkRspData_r;

	// Core side registers
	logic                reqSync1_r;
	logic                reqSync2_r;
	logic                reqSync3_r;
	logic                ackTgl_r;
	logic [15:0]         rspData_r;
	fsba_pkg::fsba_level_e level_r;
	logic [15:0]         prevWord_r;
	logic                prevValid_r;
	logic [7:0]          subclass_r;
	logic [7:0]          blockSel_r;
	logic [7:0]          srcSel_r;
	logic [7:0]          winBuf_r [fsba_pkg::BLOCK_BYTES];
	logic [7:0]          userMem_r [fsba_pkg::USER_BYTES];
	logic [15:0]         keyWord_r [fsba_pkg::NUM_KEYS];
	logic [31:0]         prdata_r;
	logic                pslverr_r;

	// Decode
	logic                reqFire;
	fsba_pkg::fsba_cmd_s cmd;
	logic                accessible;
	logic                userSelMode;
	logic                generalOk;
	logic                ctrlWr;
	logic                subWr;
	logic                srcWr;
	logic                blkWr;
	logic                winWr;
	logic                sumWr;
	logic [4:0]          winIdx;
	logic [7:0]          winSum;
	logic                sumOk;
	logic                userTarget;
	logic [1:0]          userIdx;
	logic                userWriteOk;
	logic                keyTarget;
	logic                commitUser;
	logic                commitKey;
	logic                loadUser;
	logic [1:0]          loadIdx;
	logic                loadKey;
	logic [7:0]          loadBuf [fsba_pkg::BLOCK_BYTES];
	logic                unsealPair;
	logic                fullPair;
	logic [15:0]         statusWord;
	logic [15:0]         rspNxt;
	logic                apbSetup;
	logic                apbKeyHit;
	logic                apbKeyWr;
	logic [1:0]          apbKeyIdx;
	logic                apbCtrlWr;

	// Sum seen by the host is the ones complement of the byte sum
	function automatic logic [7:0] blockChecksum(input logic [7:0] b [fsba_pkg::BLOCK_BYTES]);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < fsba_pkg::BLOCK_BYTES; i++) begin
			s = 8'(s + b[i]);
		end
		blockChecksum = ~s;
	endfunction : blockChecksum

	// Link domain: capture, hold until acknowledged
	always_ff @(posedge linkClk or negedge reset_n) begin
		if (!reset_n) begin
			linkCmd_r    <= '0;
			linkReqTgl_r <= 1'b0;
		end else if (linkReqValid && !linkBusy_r) begin
			linkCmd_r    <= '{write: linkReqWrite, addr: linkReqAddr, data: linkReqData};
			linkReqTgl_r <= ~linkReqTgl_r;
		end
	end

	always_ff @(posedge linkClk or negedge reset_n) begin
		if (!reset_n) begin
			linkAckSync1_r <= 1'b0;
			linkAckSync2_r <= 1'b0;
			linkAckSync3_r <= 1'b0;
		end else begin
			linkAckSync1_r <= ackTgl_r;
			linkAckSync2_r <= linkAckSync1_r;
			linkAckSync3_r <= linkAckSync2_r;
		end
	end

	// Answer word is stable in the core domain until the next request
	always_ff @(posedge linkClk or negedge reset_n) begin
		if (!reset_n) begin
			linkBusy_r     <= 1'b0;
			linkRspValid_r <= 1'b0;
			linkRspData_r  <= 16'h0000;
		end else begin
			linkRspValid_r <= 1'b0;
			if (linkAckSync2_r != linkAckSync3_r) begin
				linkBusy_r     <= 1'b0;
				linkRspValid_r <= 1'b1;
				linkRspData_r  <= rspData_r;
			end else if (linkReqValid && !linkBusy_r) begin
				linkBusy_r <= 1'b1;
			end
		end
	end

	assign linkBusy     = linkBusy_r;
	assign linkRspValid = linkRspValid_r;
	assign linkRspData  = linkRspData_r;

	// Core domain: request toggle crossing
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reqSync1_r <= 1'b0;
			reqSync2_r <= 1'b0;
			reqSync3_r <= 1'b0;
		end else begin
			reqSync1_r <= linkReqTgl_r;
			reqSync2_r <= reqSync1_r;
			reqSync3_r <= reqSync2_r;
		end
	end

	assign reqFire = reqSync2_r ^ reqSync3_r;
	assign cmd     = linkCmd_r;

	always_comb begin
		accessible  = (level_r != fsba_pkg::FSBA_LOADER);
		userSelMode = (level_r == fsba_pkg::FSBA_SEALED) || (srcSel_r == fsba_pkg::SRC_AUTH) ;
		generalOk   = accessible && !userSelMode;
		ctrlWr      = reqFire && cmd.write && accessible && (cmd.addr == fsba_pkg::CMD_CONTROL);
		subWr       = reqFire && cmd.write && generalOk && (cmd.addr == fsba_pkg::CMD_SUBCLASS);
		srcWr       = reqFire && cmd.write && accessible && (level_r != fsba_pkg::FSBA_SEALED)
		              && (cmd.addr == fsba_pkg::CMD_SOURCE);
		blkWr       = reqFire && cmd.write && accessible && (cmd.addr == fsba_pkg::CMD_BLOCK);
		winWr       = reqFire && cmd.write && accessible
		              && (cmd.addr >= fsba_pkg::CMD_WIN_BASE) && (cmd.addr <= fsba_pkg::CMD_WIN_LAST);
		sumWr       = reqFire && cmd.write && accessible && (cmd.addr == fsba_pkg::CMD_CHECKSUM);
		winIdx      = cmd.addr[4:0];
		winSum      = blockChecksum(winBuf_r);
		sumOk       = (cmd.data[7:0] == winSum);
		// Current target of the window for write-back
		if (userSelMode) begin
			userTarget  = (blockSel_r >= fsba_pkg::USER_BLK_A) && (blockSel_r <= fsba_pkg::USER_BLK_C);
			userIdx     = 2'(blockSel_r - fsba_pkg::USER_BLK_A);
			userWriteOk = !((level_r == fsba_pkg::FSBA_SEALED) && (blockSel_r == fsba_pkg::USER_BLK_A));
		end else begin
			userTarget  = (subclass_r == fsba_pkg::USER_SUBCLASS) && (blockSel_r < 8'(fsba_pkg::USER_BLOCKS));
			userIdx     = blockSel_r[1:0];
			userWriteOk = 1'b1;
		end
		keyTarget  = !userSelMode && (subclass_r == fsba_pkg::KEY_SUBCLASS) && (blockSel_r == 8'h00);
		commitUser = sumWr && sumOk && accessible && userTarget && userWriteOk;
		commitKey  = sumWr && sumOk && keyTarget && (level_r == fsba_pkg::FSBA_FULL);
		// Window source for a fresh block select
		if (userSelMode) begin
			loadUser = (cmd.data[7:0] >= fsba_pkg::USER_BLK_A) && (cmd.data[7:0] <= fsba_pkg::USER_BLK_C);
			loadIdx  = 2'(cmd.data[7:0] - fsba_pkg::USER_BLK_A);
			loadKey  = 1'b0;
		end else begin
			loadUser = (subclass_r == fsba_pkg::USER_SUBCLASS) && (cmd.data[7:0] < 8'(fsba_pkg::USER_BLOCKS));
			loadIdx  = cmd.data[1:0];
			loadKey  = (subclass_r == fsba_pkg::KEY_SUBCLASS) && (cmd.data[7:0] == 8'h00);
		end
		for (int i = 0; i < fsba_pkg::BLOCK_BYTES; i++) begin
			loadBuf[i] = 8'h00;
			if (loadUser) begin
				loadBuf[i] = userMem_r[int'(loadIdx) * fsba_pkg::BLOCK_BYTES + i];
			end else if (loadKey && i < 2 * fsba_pkg::NUM_KEYS) begin
				loadBuf[i] = (i % 2 == 0) ? keyWord_r[i / 2][7:0] : keyWord_r[i / 2][15:8];
			end
		end
	end

	// Second key of a pair must immediately follow the first
	always_comb begin
		unsealPair = ctrlWr && prevValid_r && (level_r == fsba_pkg::FSBA_SEALED)
		             && (prevWord_r == fsba_pkg::fsba_swap16(keyWord_r[0]))
		             && (cmd.data == fsba_pkg::fsba_swap16(keyWord_r[1]));
		fullPair   = ctrlWr && prevValid_r && (level_r == fsba_pkg::FSBA_UNSEALED)
		             && (prevWord_r == fsba_pkg::fsba_swap16(keyWord_r[2]))
		             && (cmd.data == fsba_pkg::fsba_swap16(keyWord_r[3]));
	end

	// Security level
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			level_r     <= fsba_pkg::FSBA_SEALED;
			prevWord_r  <= 16'h0000;
			prevValid_r <= 1'b0;
		end else begin
			if (ctrlWr) begin
				prevWord_r  <= cmd.data;
				prevValid_r <= !(unsealPair || fullPair);
			end
			if (unsealPair) begin
				level_r <= fsba_pkg::FSBA_UNSEALED;
			end else if (fullPair) begin
				level_r <= fsba_pkg::FSBA_FULL;
			end else if (ctrlWr && cmd.data == fsba_pkg::SUB_SEAL && level_r != fsba_pkg::FSBA_SEALED) begin
				level_r <= fsba_pkg::FSBA_SEALED;
			end else if (ctrlWr && cmd.data == fsba_pkg::SUB_LOADER && level_r == fsba_pkg::FSBA_FULL) begin
				level_r <= fsba_pkg::FSBA_LOADER;
			end else if (apbCtrlWr && pwdata[fsba_pkg::CTRL_EXIT_BIT] && level_r == fsba_pkg::FSBA_LOADER) begin
				level_r <= fsba_pkg::FSBA_SEALED;
			end
			// Anything else, a wrong pair included, keeps the level
		end
	end

	// Selection registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			subclass_r <= 8'h00;
			blockSel_r <= 8'h00;
			srcSel_r   <= fsba_pkg::SRC_GENERAL;
		end else begin
			if (subWr) begin
				subclass_r <= cmd.data[7:0];
			end
			if (blkWr) begin
				blockSel_r <= cmd.data[7:0];
			end
			if (srcWr) begin
				srcSel_r <= cmd.data[7:0];
			end
			// Unseal and loader drop back to the general route
			if (unsealPair || level_r == fsba_pkg::FSBA_LOADER) begin
				srcSel_r <= fsba_pkg::SRC_GENERAL;
			end
		end
	end

	// Command space window
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < fsba_pkg::BLOCK_BYTES; i++) begin
				winBuf_r[i] <= 8'h00;
			end
		end else if (blkWr) begin
			winBuf_r <= loadBuf;
		end else if (winWr) begin
			winBuf_r[winIdx] <= cmd.data[7:0];
		end
	end

	// User information storage; nothing reaches it without a good checksum
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < fsba_pkg::USER_BYTES; i++) begin
				userMem_r[i] <= 8'h00;
			end
		end else if (commitUser) begin
			for (int i = 0; i < fsba_pkg::BLOCK_BYTES; i++) begin
				userMem_r[int'(userIdx) * fsba_pkg::BLOCK_BYTES + i] <= winBuf_r[i];
			end
		end
	end

	// Key storage, reachable by APB or key subclass, full access only
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			keyWord_r[0] <= fsba_pkg::KEY_RST0;
			keyWord_r[1] <= fsba_pkg::KEY_RST1;
			keyWord_r[2] <= fsba_pkg::KEY_RST2;
			keyWord_r[3] <= fsba_pkg::KEY_RST3;
		end else if (commitKey) begin
			for (int k = 0; k < fsba_pkg::NUM_KEYS; k++) begin
				keyWord_r[k] <= {winBuf_r[2 * k + 1], winBuf_r[2 * k]};
			end
		end else if (apbKeyWr) begin
			keyWord_r[apbKeyIdx] <= pwdata[15:0];
		end
	end

	// Host read answers; loader mode returns zero for everything
	always_comb begin
		statusWord                        = 16'h0000;
		statusWord[fsba_pkg::STAT_SS_BIT]  = sealedFlag;
		statusWord[fsba_pkg::STAT_FAS_BIT] = fullAccessStatusFlag;
		rspNxt = 16'h0000;
		if (accessible) begin
			if (cmd.addr == fsba_pkg::CMD_CONTROL) begin
				rspNxt = statusWord;
			end else if (cmd.addr == fsba_pkg::CMD_SUBCLASS && generalOk) begin
				rspNxt = {8'h00, subclass_r};
			end else if (cmd.addr == fsba_pkg::CMD_BLOCK) begin
				rspNxt = {8'h00, blockSel_r};
			end else if (cmd.addr >= fsba_pkg::CMD_WIN_BASE && cmd.addr <= fsba_pkg::CMD_WIN_LAST) begin
				rspNxt = {8'h00, winBuf_r[winIdx]};
			end else if (cmd.addr == fsba_pkg::CMD_CHECKSUM) begin
				rspNxt = {8'h00, winSum};
			end else if (cmd.addr == fsba_pkg::CMD_SOURCE && level_r != fsba_pkg::FSBA_SEALED) begin
				rspNxt = {8'h00, srcSel_r};
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rspData_r <= 16'h0000;
			ackTgl_r  <= 1'b0;
		end else if (reqFire) begin
			rspData_r <= cmd.write ? 16'h0000 : rspNxt;
			ackTgl_r  <= ~ackTgl_r;
		end
	end

	// Status outputs derive straight from the level
	assign sealedFlag           = (level_r == fsba_pkg::FSBA_SEALED);
	assign fullAccessStatusFlag = (level_r != fsba_pkg::FSBA_FULL);
	assign securityLevel        = level_r;

	// APB: answer prepared in setup, so data comes from flops and pready is constant
	always_comb begin
		apbSetup  = psel && !penable;
		apbKeyHit = (paddr >= fsba_pkg::APB_KEY_BASE) && (paddr <= fsba_pkg::APB_KEY_LAST) && (paddr[1:0] == 2'b00);
		apbKeyIdx = paddr[3:2];
		apbKeyWr  = psel && penable && pwrite && apbKeyHit && (level_r == fsba_pkg::FSBA_FULL);
		apbCtrlWr = psel && penable && pwrite && (paddr == fsba_pkg::APB_CTRL);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (apbSetup) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
			if (paddr == fsba_pkg::APB_STATUS) begin
				prdata_r  <= {16'h0000, statusWord[15:2], securityLevel};
				pslverr_r <= pwrite;
			end else if (paddr == fsba_pkg::APB_CTRL) begin
				pslverr_r <= 1'b0;
			end else if (apbKeyHit) begin
				prdata_r  <= {16'h0000, keyWord_r[apbKeyIdx]};
				pslverr_r <= pwrite && (level_r != fsba_pkg::FSBA_FULL);
			end else begin
				pslverr_r <= 1'b1;
			end
		end
	end

	assign pready  = 1'b1;
	assign prdata  = prdata_r;
	assign pslverr = pslverr_r & psel & penable;

endmodule : fsba_top

// ### fsba_host_model.sv
// Host processor model on the far side of the command link.
// Assumes a free-running linkClk and one request outstanding at a time.
module fsba_host_model (
	// Link clock
	input  wire logic        linkClk,
	// Requests
	output logic             linkReqValid,
	output logic             linkReqWrite,
	output logic [7:0]       linkReqAddr,
	output logic [15:0]      linkReqData,
	// Answers
	input  wire logic        linkBusy,
	input  wire logic        linkRspValid,
	input  wire logic [15:0] linkRspData
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		linkReqValid = 1'h0;
		linkReqWrite = 1'h0;
		linkReqAddr  = 8'h00;
		linkReqData  = 16'h0000;
	end

	// Address and data scrambled once released, so stale values never look valid
	// Answer taken at the rising edge where the pulse stands; only the bench timeout ends the wait
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] r);
		@(posedge linkClk);
		while (linkBusy !== 1'h0)
			@(posedge linkClk);
		linkReqValid <= 1'h1;
		linkReqWrite <= w;
		linkReqAddr  <= a;
		linkReqData  <= d;
		@(posedge linkClk);
		linkReqValid <= 1'h0;
		linkReqAddr  <= ~a;
		linkReqData  <= ~d;
		do begin
			@(posedge linkClk);
		end while (linkRspValid !== 1'h1);
		r = linkRspData;
	endtask : xfer

	// Two consecutive control writes, each word byte-swapped
	task automatic key_pair(input logic [15:0] k0, input logic [15:0] k1);
		logic [15:0] r;
		xfer(1'h1, 8'h00, {k0[7:0], k0[15:8]}, r);
		xfer(1'h1, 8'h00, {k1[7:0], k1[15:8]}, r);
	endtask : key_pair
endmodule : fsba_host_model

// ### fsba_top_props.sv
// Port assertions for the access control block.
// Bound to fsba_top; both clock domains share reset_n.
module fsba_top_props (
	// System
	input wire logic        clk,
	input wire logic        reset_n,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Link
	input wire logic        linkClk,
	input wire logic        linkReqValid,
	input wire logic        linkReqWrite,
	input wire logic [7:0]  linkReqAddr,
	input wire logic [15:0] linkReqData,
	input wire logic        linkBusy,
	input wire logic        linkRspValid,
	input wire logic [15:0] linkRspData,
	// Status
	input wire logic        sealedFlag,
	input wire logic        fullAccessStatusFlag,
	input wire logic [1:0]  securityLevel
);
	sequence s_take;
		linkReqValid && !linkBusy;
	endsequence
	sequence s_key_wr;
		psel && penable && pwrite && paddr >= fsba_pkg::APB_KEY_BASE && paddr <= fsba_pkg::APB_KEY_LAST;
	endsequence

	a_sealed_flag: assert property (@(posedge clk) disable iff (!reset_n)
		sealedFlag == (securityLevel == fsba_pkg::FSBA_SEALED)
		&& (!$fell(sealedFlag) || securityLevel == fsba_pkg::FSBA_UNSEALED)) else $error("sealed flag wrong");
	a_fas_flag: assert property (@(posedge clk) disable iff (!reset_n)
		fullAccessStatusFlag == (securityLevel != fsba_pkg::FSBA_FULL)
		&& (!$fell(fullAccessStatusFlag) || $past(securityLevel) == fsba_pkg::FSBA_UNSEALED)) else $error("fas flag wrong");
	a_status_read: assert property (@(posedge clk) disable iff (!reset_n)
		psel && penable && !pwrite && paddr == fsba_pkg::APB_STATUS |-> prdata[1:0] == securityLevel
		&& prdata[14:13] == {fullAccessStatusFlag, sealedFlag} && prdata[31:15] == 17'h0) else $error("status word wrong");
	a_key_refused: assert property (@(posedge clk) disable iff (!reset_n)
		s_key_wr ##0 securityLevel != fsba_pkg::FSBA_FULL |-> pslverr) else $error("key write not refused");
	a_key_granted: assert property (@(posedge clk) disable iff (!reset_n)
		s_key_wr ##0 securityLevel == fsba_pkg::FSBA_FULL |-> !pslverr) else $error("key write refused");
	a_loader_entry: assert property (@(posedge clk) disable iff (!reset_n)
		$changed(securityLevel) && securityLevel == fsba_pkg::FSBA_LOADER |-> $past(securityLevel) == fsba_pkg::FSBA_FULL)
		else $error("loader entered from wrong level");
	a_full_entry: assert property (@(posedge clk) disable iff (!reset_n)
		$changed(securityLevel) && securityLevel == fsba_pkg::FSBA_FULL |-> $past(securityLevel) == fsba_pkg::FSBA_UNSEALED)
		else $error("full access entered from wrong level");
	a_unseal_entry: assert property (@(posedge clk) disable iff (!reset_n)
		$changed(securityLevel) && securityLevel == fsba_pkg::FSBA_UNSEALED |-> $past(securityLevel) == fsba_pkg::FSBA_SEALED)
		else $error("unsealed entered from wrong level");
	a_busy_hold: assert property (@(posedge linkClk) disable iff (!reset_n)
		s_take |=> linkBusy until linkRspValid) else $error("busy dropped early");
	a_answer_bound: assert property (@(posedge linkClk) disable iff (!reset_n)
		s_take |-> ##[2:60] linkRspValid) else $error("no link answer");
endmodule : fsba_top_props

bind fsba_top fsba_top_props fsba_top_props_i (.*);

// ### testbench.sv
// Self-checking bench for the parameter memory access block.
// Drives APB directly and the command link through the host model.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int LIMIT = 20000;

	logic        clk, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        linkClk, linkReqValid, linkReqWrite, linkBusy, linkRspValid;
	logic [7:0]  linkReqAddr;
	logic [15:0] linkReqData, linkRspData;
	logic        sealedFlag, fullAccessStatusFlag;
	logic [1:0]  securityLevel;
	int          errors = 0;
	int          comparisons = 0;
	int          cycles = 0;

	fsba_top fsba_top_i (.*);
	fsba_host_model fsba_host_model_i (.*);

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	// Link clock unrelated in phase
	initial begin
		linkClk = 1'h0;
		#2.3;
		forever #6 linkClk = ~linkClk;
	end

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test

	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			finish_test();
		end
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic ac(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] er,
		input logic ee, input string nm);
		logic [31:0] r;
		logic        e;
		@(posedge clk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		check(nm, r, er);
		check({nm, "_err"}, {31'h0, e}, {31'h0, ee});
	endtask : ac

	// Status word expected from level alone
	function automatic logic [31:0] st(input logic [1:0] l);
		st = 32'h0;
		st[14] = (l != 2'h2);
		st[13] = (l == 2'h0);
		st[1:0] = l;
	endfunction : st

	task automatic stat(input logic [1:0] l);
		ac(1'h0, 12'h000, 32'h0, st(l), 1'h0, "status");
		check("level_pin", {30'h0, securityLevel}, {30'h0, l});
		check("sealed_pin", {31'h0, sealedFlag}, {31'h0, l == 2'h0});
		check("fas_pin", {31'h0, fullAccessStatusFlag}, {31'h0, l != 2'h2});
	endtask : stat

	function automatic logic [15:0] csum(input logic [7:0] b0, input logic [7:0] b1);
		csum = {8'h00, ~(b0 + b1)};
	endfunction : csum

	task automatic lw(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] r;
		fsba_host_model_i.xfer(1'h1, a, d, r);
	endtask : lw

	task automatic lr(input logic [7:0] a, input logic [15:0] e, input string nm);
		logic [15:0] r;
		fsba_host_model_i.xfer(1'h0, a, 16'h0000, r);
		check(nm, {16'h0, r}, {16'h0, e});
	endtask : lr

	initial begin
		reset_n = 1'h0;
		psel    = 1'h0;
		penable = 1'h0;
		pwrite  = 1'h0;
		paddr   = 12'h000;
		pwdata  = 32'h0;
		repeat (20) @(posedge clk);
		reset_n <= 1'h1;
		repeat (3) @(posedge clk);
		stat(2'h0);
		lw(8'h3e, 16'h003a);
		lr(8'h3e, 16'h0000, "sealed_subclass");
		lw(8'h3f, 16'h0002);
		lw(8'h40, 16'h005a);
		lw(8'h60, csum(8'h5a, 8'h00));
		lw(8'h3f, 16'h0001);
		lw(8'h40, 16'h0011);
		lw(8'h60, csum(8'h11, 8'h00));
		lw(8'h3f, 16'h0001);
		lr(8'h40, 16'h0000, "blk_a_kept");
		lw(8'h3f, 16'h0003);
		lw(8'h40, 16'h0022);
		lr(8'h60, csum(8'h22, 8'h00), "csum_expect");
		lw(8'h60, 16'h0000);
		lw(8'h3f, 16'h0003);
		lr(8'h40, 16'h0000, "blk_c_kept");
		lw(8'h3f, 16'h0002);
		lr(8'h40, 16'h005a, "blk_b_commit");
		$display("test sealed_blocks done");
		fsba_host_model_i.key_pair(fsba_pkg::KEY_RST0, 16'h0000);
		stat(2'h0);
		lw(8'h00, 16'h3412);
		lw(8'h00, 16'h0001);
		lw(8'h00, 16'h7856);
		stat(2'h0);
		fsba_host_model_i.key_pair(fsba_pkg::KEY_RST0, fsba_pkg::KEY_RST1);
		stat(2'h1);
		ac(1'h1, 12'h010, 32'h0000abcd, {16'h0000, fsba_pkg::KEY_RST0}, 1'h1, "key_wr_unsealed");
		lw(8'h00, 16'h0f00);
		stat(2'h1);
		$display("test keys done");
		lw(8'h3e, 16'h003a);
		lw(8'h3f, 16'h0001);
		lr(8'h40, 16'h005a, "general_blk_b");
		lw(8'h41, 16'h0033);
		lw(8'h60, csum(8'h5a, 8'h33));
		lw(8'h61, 16'h0001);
		lw(8'h3f, 16'h0002);
		lr(8'h41, 16'h0033, "select_blk_b");
		$display("test unsealed done");
		fsba_host_model_i.key_pair(fsba_pkg::KEY_RST2, fsba_pkg::KEY_RST3);
		stat(2'h2);
		ac(1'h1, 12'h010, 32'h0000abcd, {16'h0000, fsba_pkg::KEY_RST0}, 1'h0, "key_wr_full");
		ac(1'h0, 12'h010, 32'h0, 32'h0000abcd, 1'h0, "key_rd");
		lw(8'h61, 16'h0000);
		lw(8'h3e, 16'h0070);
		lw(8'h3f, 16'h0000);
		lr(8'h40, 16'h00cd, "key_window");
		lw(8'h00, 16'h0f00);
		stat(2'h3);
		lr(8'h41, 16'h0000, "loader_read");
		ac(1'h1, 12'h004, 32'h1, 32'h0, 1'h0, "loader_exit");
		stat(2'h0);
		fsba_host_model_i.key_pair(16'habcd, fsba_pkg::KEY_RST1);
		stat(2'h1);
		lw(8'h00, fsba_pkg::SUB_SEAL);
		stat(2'h0);
		$display("test full_loader done");
		finish_test();
	end
endmodule : testbench
